// ---- shared/char_display_defs.svh ----
// timing, encoding and address constants of the display command core
`ifndef CHAR_DISPLAY_DEFS_SVH
`define CHAR_DISPLAY_DEFS_SVH

`define CLK_PERIOD_NS      5
`define BLINK_PERIOD_NS    1000000000
`define BLINK_HALF_CYCLES  (`BLINK_PERIOD_NS / 2 / `CLK_PERIOD_NS)

`define OP_CLEAR           8'b0000_0001
`define OP_HOME            8'b0000_001?
`define OP_ENTRY           8'b0000_01??
`define OP_ONOFF           8'b0000_1???
`define OP_GLYPH_SET       8'b01??_????
`define OP_CHAR_SET        8'b1???_????

`define BIT_ENTRY_INC      1
`define BIT_ENTRY_SHIFT    0
`define BIT_ONOFF_DISP     2
`define BIT_ONOFF_CUR      1
`define BIT_ONOFF_BLINK    0

`define CM_LINE1_LAST      7'h27
`define CM_LINE2_FIRST     7'h40
`define CM_LINE2_LAST      7'h67
`define CM_LINE_LEN        7'h28
`define CM_SHIFT_LAST      6'h27
`define CM_DEPTH           80
`define CM_HOME            7'h00
`define SPACE_CODE         8'h20
`define GLYPH_DEPTH        64
`define GLYPH_LAST         6'h3F
`define GLYPH_CODE_MASK    8'hF0
`define CURSOR_ROW         3'h7
`define PIX_ALL_ON         5'h1F
`define BUSY_FLAG_BIT      1'h0

`endif

// ---- shared/char_display_pkg.sv ----
// types shared by the display command core and its helpers
package char_display_pkg;

    typedef struct packed {
        logic       valid;
        logic       data_sel;
        logic       rd;
        logic [7:0] data;
    } host_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } host_rsp_t;

    typedef struct packed {
        logic       line;
        logic [4:0] pos;
        logic [2:0] row;
    } scan_req_t;

    typedef struct packed {
        logic       lit;
        logic       user;
        logic       force_on;
        logic [7:0] code;
        logic [4:0] pix;
    } scan_rsp_t;

    typedef enum {
        CMD_NONE,
        CMD_CLEAR,
        CMD_HOME,
        CMD_ENTRY,
        CMD_ONOFF,
        CMD_GLYPH_SET,
        CMD_CHAR_SET
    } cmd_kind_t;

    typedef struct packed {
        logic [79:0][7:0] cmem;
        logic [63:0][4:0] gmem;
        logic [6:0]       addr_counter;
        logic             glyph_sel;
        logic [5:0]       shift;
        logic             inc;
        logic             shift_en;
        logic             disp_on;
        logic             cur_on;
        logic             blink_on;
        host_rsp_t        rsp;
        scan_rsp_t        scan;
    } core_state_t;

endpackage

// ---- src/addr_step.sv ----
// next address counter value after one memory access
`timescale 1ns/100ps
`include "char_display_defs.svh"

module addr_step (
    input  wire logic [6:0] addr_counter,
    input  wire logic       glyph_sel,
    input  wire logic       inc,
    output logic      [6:0] next_addr
);
    always_comb begin
        if (glyph_sel) begin
            // glyph space wraps within six bits
            next_addr = {1'b0, inc ? addr_counter[5:0] + 6'h01 : addr_counter[5:0] - 6'h01};
        end else if (inc) begin
            if (addr_counter == `CM_LINE1_LAST) begin
                next_addr = `CM_LINE2_FIRST;
            end else if (addr_counter == `CM_LINE2_LAST) begin
                next_addr = `CM_HOME;
            end else begin
                next_addr = addr_counter + 7'h01;
            end
        end else begin
            if (addr_counter == `CM_LINE2_FIRST) begin
                next_addr = `CM_LINE1_LAST;
            end else if (addr_counter == `CM_HOME) begin
                next_addr = `CM_LINE2_LAST;
            end else begin
                next_addr = addr_counter - 7'h01;
            end
        end
    end
endmodule

// ---- src/blink_timer.sv ----
// half-period divider giving the blink phase
`timescale 1ns/100ps

module blink_timer #(
    parameter int HALF_CYCLES = 100000000
) (
    input  wire logic ref_clk,
    input  wire logic reset,
    output logic      phase
);
    generate
        if (HALF_CYCLES < 2) begin : g_bad
            $error("blink half period too short");
        end
    endgenerate

    typedef struct packed {
        logic [31:0] cnt;
        logic        phase;
    } blink_state_t;

    blink_state_t st_ff;
    blink_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (st_ff.cnt == 32'(HALF_CYCLES - 1)) begin
            nxt_st.cnt   = 32'h0;
            nxt_st.phase = ~st_ff.phase;
        end else begin
            nxt_st.cnt = st_ff.cnt + 32'h1;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign phase = st_ff.phase;
endmodule

// ---- src/char_display_core.sv ----
// command core of the two-line character display
//
// Summary of operation
// - character memory answers only at 00H-27H and 40H-67H, one byte each
// - locations off screen still store and return written bytes
// - unshifted, line one shows 00-13 and line two 40-53
// - left shift moves both windows up by one address
// - right shift moves windows down, wrapping within the line to 27 and 67
// - glyph memory has 64 locations; a one bit lights a pixel
// - codes 00H-0FH select the eight user glyphs, bit 3 ignored
// - glyph address is code bits 2-0 then pixel row; data bits 4-0
// - glyph memory keeps only the lower five bits of each byte
// - clear fills character memory with 20H and homes the counter
// - clear also unshifts the display and sets increment direction
// - home zeroes the counter and unshifts, memories untouched
// - entry mode stores direction and shift; zero decrements, shifts right
// - direction one increments; shifting moves display left after writes
// - auto shift only after character memory writes
// - on/off stores display, cursor and blink bits
// - blink alternates cursor character with all pixels on, 50% duty
// - counter steps 27H/40H and 67H/00H; glyph addresses wrap at 3FH
// - glyph and character address set load counter and select memory
// - instruction read returns counter with busy bit zero
// - power-up state: spaces, counter 00H, unshifted, inc, everything off
`timescale 1ns/100ps
`include "char_display_defs.svh"

module char_display_core #(
    parameter int BLINK_HALF_CYCLES = `BLINK_HALF_CYCLES
) (
    input  wire logic                         ref_clk,
    input  wire logic                         reset,
    input  wire char_display_pkg::host_req_t  host_req,
    output char_display_pkg::host_rsp_t       host_rsp,
    input  wire char_display_pkg::scan_req_t  scan_req,
    output char_display_pkg::scan_rsp_t       scan_rsp
);
    import char_display_pkg::*;

    generate
        if (BLINK_HALF_CYCLES < 2) begin : g_bad_blink
            $error("blink half period too short");
        end
    endgenerate

    function automatic logic cm_valid(input logic [6:0] a);
        return (a <= `CM_LINE1_LAST) ||
               (a >= `CM_LINE2_FIRST && a <= `CM_LINE2_LAST);
    endfunction

    // line one packs into 0-39, line two into 40-79
    function automatic logic [6:0] cm_index(input logic [6:0] a);
        return {1'b0, a[5:0]} + (a[6] ? `CM_LINE_LEN : 7'h00);
    endfunction

    function automatic cmd_kind_t decode(input logic [7:0] b);
        casez (b)
            `OP_CHAR_SET:  decode = CMD_CHAR_SET;
            `OP_GLYPH_SET: decode = CMD_GLYPH_SET;
            `OP_ONOFF:     decode = CMD_ONOFF;
            `OP_ENTRY:     decode = CMD_ENTRY;
            `OP_HOME:      decode = CMD_HOME;
            `OP_CLEAR:     decode = CMD_CLEAR;
            default:       decode = CMD_NONE;
        endcase
    endfunction

    function automatic core_state_t rst_state();
        core_state_t s;
        s = '0;
        s.cmem = {`CM_DEPTH{`SPACE_CODE}};
        s.inc  = 1'b1;
        return s;
    endfunction

    localparam core_state_t RST_STATE = rst_state();

    core_state_t st_ff;
    core_state_t nxt_st;
    logic [6:0]  step_addr;
    logic        blink_phase;
    cmd_kind_t   kind;
    logic [6:0]  col_sum;
    logic [6:0]  scan_addr;
    logic [6:0]  acc_idx;
    logic [7:0]  scan_code;
    logic        at_cursor;

    addr_step u_step (
        .addr_counter (st_ff.addr_counter),
        .glyph_sel    (st_ff.glyph_sel),
        .inc          (st_ff.inc),
        .next_addr    (step_addr)
    );

    blink_timer #(
        .HALF_CYCLES (BLINK_HALF_CYCLES)
    ) u_blink (
        .ref_clk (ref_clk),
        .reset   (reset),
        .phase   (blink_phase)
    );

    always_comb begin
        nxt_st           = st_ff;
        nxt_st.rsp.valid = 1'b0;
        kind             = decode(host_req.data);
        acc_idx          = cm_index(st_ff.addr_counter);

        // display window: position plus shift, wrapping inside the line
        col_sum = {2'b00, scan_req.pos} + {1'b0, st_ff.shift};
        if (col_sum >= `CM_LINE_LEN) begin
            col_sum = col_sum - `CM_LINE_LEN;
        end
        scan_addr = {scan_req.line, col_sum[5:0]};
        scan_code = st_ff.cmem[cm_index(scan_addr)];
        at_cursor = !st_ff.glyph_sel && (scan_addr == st_ff.addr_counter);

        nxt_st.scan.lit      = st_ff.disp_on;
        nxt_st.scan.code     = scan_code;
        nxt_st.scan.user     = (scan_code & `GLYPH_CODE_MASK) == 8'h00;
        nxt_st.scan.force_on = 1'b0;
        nxt_st.scan.pix      = nxt_st.scan.user ?
                               st_ff.gmem[{scan_code[2:0], scan_req.row}] : 5'h00;
        if (st_ff.cur_on && at_cursor && scan_req.row == `CURSOR_ROW) begin
            nxt_st.scan.force_on = 1'b1;
        end
        if (st_ff.blink_on && at_cursor && blink_phase) begin
            nxt_st.scan.force_on = 1'b1;
        end
        if (nxt_st.scan.force_on) begin
            nxt_st.scan.pix = `PIX_ALL_ON;
        end
        if (!st_ff.disp_on) begin
            nxt_st.scan.force_on = 1'b0;
            nxt_st.scan.pix      = 5'h00;
        end

        // every command completes here in the cycle it is taken
        if (host_req.valid && host_req.data_sel) begin
            if (st_ff.glyph_sel) begin
                if (host_req.rd) begin
                    nxt_st.rsp.valid = 1'b1;
                    nxt_st.rsp.data  = {3'h0, st_ff.gmem[st_ff.addr_counter[5:0]]};
                end else begin
                    nxt_st.gmem[st_ff.addr_counter[5:0]] = host_req.data[4:0];
                end
            end else begin
                if (host_req.rd) begin
                    nxt_st.rsp.valid = 1'b1;
                    nxt_st.rsp.data  = cm_valid(st_ff.addr_counter) ?
                                       st_ff.cmem[acc_idx] : 8'h00;
                end else begin
                    if (cm_valid(st_ff.addr_counter)) begin
                        nxt_st.cmem[acc_idx] = host_req.data;
                    end
                    if (st_ff.shift_en) begin
                        if (st_ff.inc) begin
                            nxt_st.shift = (st_ff.shift == `CM_SHIFT_LAST) ?
                                           6'h00 : st_ff.shift + 6'h01;
                        end else begin
                            nxt_st.shift = (st_ff.shift == 6'h00) ?
                                           `CM_SHIFT_LAST : st_ff.shift - 6'h01;
                        end
                    end
                end
            end
            nxt_st.addr_counter = step_addr;
        end else if (host_req.valid && host_req.rd) begin
            nxt_st.rsp.valid = 1'b1;
            nxt_st.rsp.data  = {`BUSY_FLAG_BIT, st_ff.addr_counter};
        end else if (host_req.valid) begin
            case (kind)
                CMD_CLEAR: begin
                    nxt_st.cmem         = {`CM_DEPTH{`SPACE_CODE}};
                    nxt_st.addr_counter = `CM_HOME;
                    nxt_st.glyph_sel    = 1'b0;
                    nxt_st.shift        = 6'h00;
                    nxt_st.inc          = 1'b1;
                end
                CMD_HOME: begin
                    nxt_st.addr_counter = `CM_HOME;
                    nxt_st.glyph_sel    = 1'b0;
                    nxt_st.shift        = 6'h00;
                end
                CMD_ENTRY: begin
                    nxt_st.inc      = host_req.data[`BIT_ENTRY_INC];
                    nxt_st.shift_en = host_req.data[`BIT_ENTRY_SHIFT];
                end
                CMD_ONOFF: begin
                    nxt_st.disp_on  = host_req.data[`BIT_ONOFF_DISP];
                    nxt_st.cur_on   = host_req.data[`BIT_ONOFF_CUR];
                    nxt_st.blink_on = host_req.data[`BIT_ONOFF_BLINK];
                end
                CMD_GLYPH_SET: begin
                    nxt_st.addr_counter = {1'b0, host_req.data[5:0]};
                    nxt_st.glyph_sel    = 1'b1;
                end
                CMD_CHAR_SET: begin
                    nxt_st.addr_counter = host_req.data[6:0];
                    nxt_st.glyph_sel    = 1'b0;
                end
                default: begin
                    nxt_st.rsp.valid = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            st_ff <= RST_STATE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign host_rsp = st_ff.rsp;
    assign scan_rsp = st_ff.scan;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    logic ins_wr;
    logic dat_wr;
    logic dat_rd;
    assign ins_wr = host_req.valid && !host_req.data_sel && !host_req.rd;
    assign dat_wr = host_req.valid && host_req.data_sel && !host_req.rd;
    assign dat_rd = host_req.valid && host_req.data_sel && host_req.rd;

    property p_clear;
        ins_wr && host_req.data == `OP_CLEAR |=>
            st_ff.addr_counter == `CM_HOME && st_ff.inc && st_ff.shift == 6'h00 &&
            st_ff.cmem[0] == `SPACE_CODE && st_ff.cmem[79] == `SPACE_CODE;
    endproperty
    a_clear: assert property (p_clear) else $error("clear incomplete");

    property p_home;
        ins_wr && decode(host_req.data) == CMD_HOME |=>
            st_ff.addr_counter == `CM_HOME && st_ff.shift == 6'h00 &&
            st_ff.cmem == $past(st_ff.cmem);
    endproperty
    a_home: assert property (p_home) else $error("home wrong");

    property p_entry;
        ins_wr && decode(host_req.data) == CMD_ENTRY |=>
            st_ff.inc == $past(host_req.data[1]) &&
            st_ff.shift_en == $past(host_req.data[0]);
    endproperty
    a_entry: assert property (p_entry) else $error("entry bits not stored");

    property p_onoff;
        ins_wr && decode(host_req.data) == CMD_ONOFF |=>
            {st_ff.disp_on, st_ff.cur_on, st_ff.blink_on} == $past(host_req.data[2:0]);
    endproperty
    a_onoff: assert property (p_onoff) else $error("on/off bits not stored");

    property p_ac_read;
        host_req.valid && !host_req.data_sel && host_req.rd |=>
            host_rsp.valid && host_rsp.data == {1'b0, $past(st_ff.addr_counter)};
    endproperty
    a_ac_read: assert property (p_ac_read) else $error("counter read wrong");

    property p_wrap;
        dat_wr && !st_ff.glyph_sel && st_ff.inc && st_ff.addr_counter == `CM_LINE1_LAST
            |=> st_ff.addr_counter == `CM_LINE2_FIRST;
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter wrap wrong");

    property p_no_shift;
        (dat_rd || (dat_wr && st_ff.glyph_sel)) |=> $stable(st_ff.shift);
    endproperty
    a_no_shift: assert property (p_no_shift) else $error("shift on read");

    property p_left;
        dat_wr && !st_ff.glyph_sel && st_ff.shift_en && st_ff.inc && st_ff.shift == 6'h00
            |=> st_ff.shift == 6'h01;
    endproperty
    a_left: assert property (p_left) else $error("left shift wrong");

    property p_glyph_rd;
        dat_rd && st_ff.glyph_sel |=> host_rsp.valid && host_rsp.data[7:5] == 3'h0;
    endproperty
    a_glyph_rd: assert property (p_glyph_rd) else $error("glyph high bits");

    property p_glyph_set;
        ins_wr && decode(host_req.data) == CMD_GLYPH_SET |=>
            st_ff.glyph_sel && st_ff.addr_counter == {1'b0, $past(host_req.data[5:0])};
    endproperty
    a_glyph_set: assert property (p_glyph_set) else $error("glyph set wrong");

    property p_cm_write;
        dat_wr && !st_ff.glyph_sel && cm_valid(st_ff.addr_counter) |=>
            st_ff.cmem[$past(acc_idx)] == $past(host_req.data);
    endproperty
    a_cm_write: assert property (p_cm_write) else $error("character write lost");

    property p_unmapped;
        dat_rd && !st_ff.glyph_sel && !cm_valid(st_ff.addr_counter) |=>
            host_rsp.valid && host_rsp.data == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    property p_glyph_wr;
        dat_wr && st_ff.glyph_sel |=>
            st_ff.gmem[$past(st_ff.addr_counter[5:0])] == $past(host_req.data[4:0]);
    endproperty
    a_glyph_wr: assert property (p_glyph_wr) else $error("glyph write lost");

    property p_right;
        dat_wr && !st_ff.glyph_sel && st_ff.shift_en && !st_ff.inc && st_ff.shift == 6'h00
            |=> st_ff.shift == `CM_SHIFT_LAST;
    endproperty
    a_right: assert property (p_right) else $error("right shift wrong");

    property p_dec_wrap;
        (dat_wr || dat_rd) && !st_ff.glyph_sel && !st_ff.inc && st_ff.addr_counter == `CM_HOME
            |=> st_ff.addr_counter == `CM_LINE2_LAST;
    endproperty
    a_dec_wrap: assert property (p_dec_wrap) else $error("counter underflow wrong");

    property p_glyph_wrap;
        (dat_wr || dat_rd) && st_ff.glyph_sel && st_ff.inc &&
            st_ff.addr_counter[5:0] == `GLYPH_LAST |=> st_ff.addr_counter == 7'h00;
    endproperty
    a_glyph_wrap: assert property (p_glyph_wrap) else $error("glyph wrap wrong");

    property p_dark;
        !st_ff.disp_on |=> scan_rsp.pix == 5'h00 && !scan_rsp.force_on;
    endproperty
    a_dark: assert property (p_dark) else $error("blank display lit");

    property p_cursor;
        st_ff.disp_on && st_ff.cur_on && at_cursor && scan_req.row == `CURSOR_ROW
            |=> scan_rsp.force_on && scan_rsp.pix == `PIX_ALL_ON;
    endproperty
    a_cursor: assert property (p_cursor) else $error("cursor row missing");

    property p_blink;
        st_ff.disp_on && st_ff.blink_on && at_cursor && blink_phase
            |=> scan_rsp.force_on && scan_rsp.pix == `PIX_ALL_ON;
    endproperty
    a_blink: assert property (p_blink) else $error("blink phase not shown");

    c_clear:  cover property (ins_wr && host_req.data == `OP_CLEAR);
    c_shift:  cover property (dat_wr && st_ff.shift_en && !st_ff.glyph_sel);
    c_glyph:  cover property (dat_wr && st_ff.glyph_sel);
    c_cursor: cover property (scan_rsp.force_on && scan_rsp.lit);
    c_blink:  cover property (st_ff.blink_on && at_cursor && blink_phase && st_ff.disp_on);
endmodule

// ---- tb/host_model.sv ----
// host side model issuing instruction and data bytes
`timescale 1ns/100ps

module host_model (
    input  wire logic                        ref_clk,
    input  wire char_display_pkg::host_rsp_t host_rsp,
    output char_display_pkg::host_req_t      host_req
);
    import char_display_pkg::*;

    initial host_req = '0;

    // one idle cycle between transfers, so valid is never driven twice in a step
    task automatic xfer(input logic sel, input logic rd, input logic [7:0] data,
                        output logic [7:0] got);
        @(negedge ref_clk);
        host_req = '{valid: 1'b1, data_sel: sel, rd: rd, data: data};
        @(negedge ref_clk);
        host_req.valid = 1'b0;
        // released bus must not keep showing the old byte
        host_req.data = ~data;
        got = host_rsp.valid ? host_rsp.data : 8'hXX;
    endtask
endmodule

// ---- tb/char_display_command_core_bench.sv ----
// self-checking bench of the display command core
`timescale 1ns/100ps

module char_display_command_core_bench;
    import char_display_pkg::*;

    // short blink half period keeps the run brief
    localparam int HALF = 8;

    logic       ref_clk     = 1'b0;
    logic       reset       = 1'b1;
    host_req_t  host_req;
    host_rsp_t  host_rsp;
    scan_req_t  scan_req    = '0;
    scan_rsp_t  scan_rsp;
    int         err_count   = 0;
    int         comparisons = 0;
    integer     seed        = 32'hEDF98C58;
    logic [7:0] rd_byte;
    logic [7:0] val [4];
    logic [7:0] cnt;
    logic       dir;
    logic [6:0] adr;
    logic [5:0] gad;
    logic [7:0] byt;

    always #2.5 ref_clk = ~ref_clk;

    host_model i_host (
        .ref_clk  (ref_clk),
        .host_rsp (host_rsp),
        .host_req (host_req)
    );

    char_display_core #(.BLINK_HALF_CYCLES(HALF)) i_dut (
        .ref_clk  (ref_clk),
        .reset    (reset),
        .host_req (host_req),
        .host_rsp (host_rsp),
        .scan_req (scan_req),
        .scan_rsp (scan_rsp)
    );

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // counter after one character access, with the line wraps
    function automatic logic [6:0] exp_step(input logic [6:0] a, input logic up);
        if (up) begin
            return (a == 7'h27) ? 7'h40 : ((a == 7'h67) ? 7'h00 : a + 7'h01);
        end
        return (a == 7'h40) ? 7'h27 : ((a == 7'h00) ? 7'h67 : a - 7'h01);
    endfunction

    // off-range character addresses drop writes and read back zero
    function automatic logic [7:0] exp_read(input logic [6:0] a, input logic [7:0] b);
        return (a <= 7'h27 || (a >= 7'h40 && a <= 7'h67)) ? b : 8'h00;
    endfunction

    task automatic end_sim;
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic cmd(input logic [7:0] b);
        i_host.xfer(1'b0, 1'b0, b, rd_byte);
    endtask

    task automatic wr(input logic [7:0] b);
        i_host.xfer(1'b1, 1'b0, b, rd_byte);
    endtask

    // sel 0 reads the counter, sel 1 the addressed memory
    task automatic rd(input logic sel);
        i_host.xfer(sel, 1'b1, 8'h00, rd_byte);
    endtask

    task automatic scan(input logic line, input logic [4:0] pos, input logic [2:0] row);
        @(negedge ref_clk);
        scan_req = '{line: line, pos: pos, row: row};
        @(negedge ref_clk);
    endtask

    initial begin
        #100000;
        err_count++;
        end_sim();
    end

    initial begin
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        reset = 1'b0;
        rd(1'b0); chk("counter", rd_byte, 8'h00);
        rd(1'b1); chk("char", rd_byte, 8'h20);
        // crossing the end of line one
        cmd(8'hA6);
        for (int i = 0; i < 4; i++) begin
            val[i] = 8'($random(seed));
            wr(val[i]);
        end
        rd(1'b0); chk("counter", rd_byte, 8'h42);
        cmd(8'hA6);
        for (int i = 0; i < 4; i++) begin
            rd(1'b1); chk("char", rd_byte, val[i]);
        end
        cmd(8'hA8); wr(8'h55); cmd(8'hA8);
        rd(1'b1); chk("unmapped", rd_byte, 8'h00);
        // glyph side wraps at the top
        cmd(8'h7F); wr(val[0]); wr(val[1]);
        rd(1'b0); chk("counter", rd_byte, 8'h01);
        cmd(8'h7F);
        rd(1'b1); chk("glyph", rd_byte, {3'h0, val[0][4:0]});
        // glyph 3 row 2 shown through alias code 0B
        cmd(8'h5A); wr(val[2]);
        cmd(8'h80); wr(8'h0B);
        scan(1'b0, 5'h00, 3'h2); chk("lit", {7'h0, scan_rsp.lit}, 8'h00);
        cmd(8'h0C);
        scan(1'b0, 5'h00, 3'h2); chk("pix", {3'h0, scan_rsp.pix}, {3'h0, val[2][4:0]});
        chk("user", {7'h0, scan_rsp.user}, 8'h01);
        scan(1'b1, 5'h13, 3'h0); chk("code", scan_rsp.code, 8'h20);
        // shift left on write, never on read
        cmd(8'hD4); wr(8'h4B); cmd(8'hE7); wr(8'h4C);
        cmd(8'h07); cmd(8'h80); wr(8'h41);
        scan(1'b1, 5'h13, 3'h0); chk("code", scan_rsp.code, 8'h4B);
        cmd(8'h80); rd(1'b1);
        scan(1'b1, 5'h13, 3'h0); chk("code", scan_rsp.code, 8'h4B);
        // two right shifts end one step right of home
        cmd(8'h05); cmd(8'h81); wr(8'h61); wr(8'h62);
        scan(1'b1, 5'h00, 3'h0); chk("code", scan_rsp.code, 8'h4C);
        rd(1'b0); chk("counter", rd_byte, 8'h67);
        cmd(8'h0E);
        scan(1'b1, 5'h00, 3'h7); chk("cursor", {7'h0, scan_rsp.force_on}, 8'h01);
        scan(1'b1, 5'h01, 3'h7); chk("cursor", {7'h0, scan_rsp.force_on}, 8'h00);
        cmd(8'h02);
        rd(1'b0); chk("counter", rd_byte, 8'h00);
        scan(1'b0, 5'h00, 3'h0); chk("code", scan_rsp.code, 8'h62);
        // any 4*HALF cycles hold exactly 2*HALF cycles of high phase
        cmd(8'h0D);
        scan(1'b0, 5'h00, 3'h3);
        cnt = 8'h00;
        for (int i = 0; i < 4 * HALF; i++) begin
            @(negedge ref_clk);
            cnt = cnt + {7'h0, scan_rsp.force_on};
        end
        chk("blink", cnt, 8'(2 * HALF));
        cmd(8'h01);
        rd(1'b0); chk("counter", rd_byte, 8'h00);
        rd(1'b1); chk("char", rd_byte, 8'h20);
        rd(1'b0); chk("counter", rd_byte, 8'h01);
        cmd(8'h5A);
        rd(1'b1); chk("glyph", rd_byte, {3'h0, val[2][4:0]});
        cmd(8'h3C); cmd(8'h0F);
        rd(1'b0); chk("counter", rd_byte, 8'h1B);
        // mid-run reset returns the power-up state
        @(negedge ref_clk);
        reset = 1'b1;
        @(negedge ref_clk);
        reset = 1'b0;
        rd(1'b0); chk("counter", rd_byte, 8'h00);
        scan(1'b0, 5'h00, 3'h7); chk("lit", {7'h0, scan_rsp.lit}, 8'h00);
        // random direction, address and byte on both memories
        for (int i = 0; i < 24; i++) begin
            dir = 1'($random(seed));
            adr = 7'($random(seed));
            gad = 6'($random(seed));
            byt = 8'($random(seed));
            cmd({6'h01, dir, 1'b0});
            cmd({1'b1, adr}); wr(byt);
            rd(1'b0); chk("counter", rd_byte, {1'b0, exp_step(adr, dir)});
            cmd({1'b1, adr});
            rd(1'b1); chk("char", rd_byte, exp_read(adr, byt));
            cmd({2'b01, gad}); wr(byt);
            rd(1'b0); chk("counter", rd_byte, {2'b00, dir ? gad + 6'h01 : gad - 6'h01});
            cmd({2'b01, gad});
            rd(1'b1); chk("glyph", rd_byte, {3'h0, byt[4:0]});
        end
        end_sim();
    end
endmodule
